/* File: src/hsdv_div_count.sv */
// Divider counter with separate high and low lengths, counted in input ticks.
// Assumes highLen and lowLen are at least one while run is high.
`default_nettype none
module hsdv_div_count
   import hsdv_pkg::*;
#(
   parameter int W = 9
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Control
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] highLen,
   input wire logic [W-1:0] lowLen,
   // Divided clock
   output logic divOut,
   output logic divRise,
   output logic divEdge
);
   typedef struct packed
   {
      logic out;
      logic [W-1:0] cnt;
   } hsdv_div_st_t;

   hsdv_div_st_t state_reg;
   hsdv_div_st_t state_next;
   logic [W-1:0] lenNow;
   logic atEnd;

   assign lenNow = state_reg.out ? highLen : lowLen;
   // Compare with >= so a length shortened mid-phase cannot run the count away
   assign atEnd = (state_reg.cnt >= lenNow - W'(1));
   assign divEdge = run && tick && atEnd;
   assign divRise = divEdge && !state_reg.out;
   assign divOut = state_reg.out;

   always_comb
   begin
      state_next = state_reg;
      if (!run)
      begin
         state_next = '0;
      end
      else if (tick)
      begin
         if (atEnd)
         begin
            // Equal high and low lengths give an even split for odd ratios
            state_next.out = !state_reg.out;
            state_next.cnt = '0;
         end
         else
            state_next.cnt = state_reg.cnt + W'(1);
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_reg <= '0;
      else if (ce)
         state_reg <= state_next;
   end

   AST_CNT_BOUND: assert property (@(posedge core_clk) disable iff (sys_rst)
      run && state_reg.out && state_reg.cnt < highLen
      |=> !run || !state_reg.out || !$stable(highLen) || state_reg.cnt < highLen)
      else $error("high phase overran its length");
endmodule : hsdv_div_count
`default_nettype wire

/* File: src/hsdv_edge.sv */
// Rise and fall detector for a vector of synchronous levels.
// Assumes inputs are already synchronous to core_clk.
`default_nettype none
module hsdv_edge
   import hsdv_pkg::*;
#(
   parameter int W = 1
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Levels and events
   input wire logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   typedef struct packed
   {
      logic [W-1:0] prev;
   } hsdv_edge_st_t;

   hsdv_edge_st_t state_reg;
   hsdv_edge_st_t state_next;

   always_comb
   begin
      state_next = state_reg;
      state_next.prev = level;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_reg <= '0;
      else if (ce)
         state_reg <= state_next;
   end

   assign rise = {W{ce}} & level & ~state_reg.prev;
   assign fall = {W{ce}} & ~level & state_reg.prev;

   AST_EDGE_EXCL: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise & fall) == '0) else $error("rise and fall together");
endmodule : hsdv_edge
`default_nettype wire

/* File: src/hsdv_output_stage.sv */
// Per-output clock stage: source select, medium and low dividers, duty shaping,
// format and polarity, plus the arm/trigger phase adjust sequencer.
// Assumes config and event inputs are synchronous to core_clk.
//
// How it works
// - Format picks off, CML, HSTL or CMOS; off floats pins, low power.
// - Polarity one inverts the clock sent to the driver.
// - Divider select picks high-speed divider one or two as source.
// - Seven-bit medium divider feeds twenty-five-bit low divider in series.
// - Both dividers keep fifty percent duty for every ratio, odd included.
// - Low divider works only when the medium ratio is above zero.
// - Dual-frequency mode: positive pin from medium, negative adds low divider.
// - Duty shaping needs medium ratio above zero, low above one; zero gives half.
// - Nonzero pulse width gives a pulse of that many medium periods.
// - Polarity zero gives high pulse; polarity one gives low pulse.
// - Shaping lives in low divider; dual mode shapes only negative pin.
// - Phase steps happen in medium divider at half high-speed periods.
// - Arm source: arm bit rise, analog lock, digital lock or GPIO edge.
// - Trigger source: bit rise, locks, digital input rise, GPIO; optional invert.
// - Trigger adjusts only enabled outputs with a nonzero step.
// - Step needs medium ratio above zero and is clamped to ratio limits.
// - Adjustment changes one medium period: positive longer high, negative shorter.
// - Sequencer reset cancels a pending arm and returns to idle.
// - Status shows armed, busy, and a sticky done flag.
`default_nettype none
module hsdv_output_stage
   import hsdv_pkg::*;
(
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // High-speed divider half-period strobes
   input wire logic hsHalfTick1,
   input wire logic hsHalfTick2,
   // Configuration
   input wire hsdv_cfg_t cfg,
   input wire hsdv_phase_t phaseCfg,
   // Arm and trigger sources
   input wire logic armRequestBit,
   input wire logic triggerRequestBit,
   input wire logic analogPllLock,
   input wire logic digitalPllLock,
   input wire logic digitalPllInClk,
   input wire logic [3:0] gpioIn,
   input wire logic sequencerReset,
   input wire logic adjustDoneClear,
   // Output pins
   output logic positiveOutputPin,
   output logic positiveOutputOeN,
   output logic negativeOutputPin,
   output logic negativeOutputOeN,
   output logic driverLowPower,
   // Status
   output hsdv_status_t phaseStatusReg
);
   // ==========================================================
   // State
   typedef struct packed
   {
      hsdv_seq_t seq;
      logic adjPending;
      logic adjActive;
      logic doneLatch;
      logic hsLevel;
      logic posOut;
      logic negOut;
      logic posOeN;
      logic negOeN;
      logic lowPower;
   } hsdv_stage_st_t;

   hsdv_stage_st_t state_reg;
   hsdv_stage_st_t state_next;

   // ==========================================================
   // Source clock and enables
   logic hsTick;
   logic stageRun;
   logic medUsed;
   logic lowRun;
   logic dualMode;
   logic dutyOn;

   assign hsTick = cfg.hsDividerSelect ? hsHalfTick2 : hsHalfTick1;
   assign stageRun = cfg.dividerEnable && (cfg.outputFormatSelect != FMT_OFF);
   assign medUsed = stageRun && (cfg.mediumDividerRatio != '0);
   assign dualMode = !cfg.lowDividerRoute && cfg.negativePinLowDivider;
   // Low divider is held in reset without a medium divider in front of it
   assign lowRun = medUsed && (cfg.lowDividerRoute || dualMode);
   assign dutyOn = (cfg.pulseWidthCount != '0) && (cfg.lowDividerRatio >= LOW_DUTY_MIN)
      && (LOW_W'(cfg.pulseWidthCount) <= cfg.lowDividerRatio);

   // ==========================================================
   // Phase step clamp, in half high-speed periods
   logic [MED_W:0] negLimit;
   logic [MED_W:0] posLimit;
   logic signed [MCNT_W:0] stepWide;
   logic signed [MCNT_W:0] stepClamped;

   always_comb
   begin
      negLimit = cfg.mediumDividerRatio[0] ? {1'b0, cfg.mediumDividerRatio} - 8'h01
         : {1'b0, cfg.mediumDividerRatio} - 8'h02;
      if (cfg.mediumDividerRatio == '0)
         negLimit = '0;
      posLimit = cfg.mediumDividerRatio[0] ? MED_POS_ODD - {1'b0, cfg.mediumDividerRatio}
         : MED_POS_EVEN - {1'b0, cfg.mediumDividerRatio};
      stepWide = {{(MCNT_W+1-STEP_W){phaseCfg.phaseStepAmount[STEP_W-1]}},
         phaseCfg.phaseStepAmount};
      stepClamped = stepWide;
      if (stepWide > $signed({2'b00, posLimit}))
         stepClamped = $signed({2'b00, posLimit});
      if (stepWide < -$signed({2'b00, negLimit}))
         stepClamped = -$signed({2'b00, negLimit});
   end

   // ==========================================================
   // Medium divider: counts half ticks, period 2*(ratio+1)
   logic [MCNT_W-1:0] medBase;
   logic [MCNT_W-1:0] medHigh;
   logic medOut;
   logic medRise;
   logic medEdge;

   assign medBase = {2'b00, cfg.mediumDividerRatio} + MCNT_W'(1);
   // Step alters the high time of exactly one medium period
   assign medHigh = state_reg.adjActive
      ? MCNT_W'($signed({1'b0, medBase}) + stepClamped) : medBase;

   hsdv_div_count #(.W(MCNT_W)) medDiv
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .run(medUsed),
      .tick(hsTick),
      .highLen(medHigh),
      .lowLen(medBase),
      .divOut(medOut),
      .divRise(medRise),
      .divEdge(medEdge)
   );

   // ==========================================================
   // Low divider: counts medium edges, period 2*(ratio+1)
   logic [LCNT_W-1:0] lowPeriod;
   logic [LCNT_W-1:0] lowHigh;
   logic [LCNT_W-1:0] lowLow;
   logic lowOut;

   assign lowPeriod = {cfg.lowDividerRatio, 1'b0} + LCNT_W'(2);
   assign lowHigh = dutyOn ? LCNT_W'({cfg.pulseWidthCount, 1'b0})
      : LCNT_W'({2'b00, cfg.lowDividerRatio} + LCNT_W'(1));
   assign lowLow = lowPeriod - lowHigh;

   hsdv_div_count #(.W(LCNT_W)) lowDiv
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .run(lowRun),
      .tick(medEdge),
      .highLen(lowHigh),
      .lowLen(lowLow),
      .divOut(lowOut),
      .divRise(),
      .divEdge()
   );

   // ==========================================================
   // Arm and trigger events
   logic [EV_W-1:0] evLevel;
   logic [EV_W-1:0] evRise;
   logic [EV_W-1:0] evFall;
   logic armEvent;
   logic trigEvent;
   logic [1:0] armGpio;
   logic [1:0] trgGpio;

   assign evLevel = {gpioIn, digitalPllInClk, digitalPllLock, analogPllLock,
      triggerRequestBit, armRequestBit};

   hsdv_edge #(.W(EV_W)) evDet
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .level(evLevel),
      .rise(evRise),
      .fall(evFall)
   );

   assign armGpio = phaseCfg.armSourceSelect[1:0];
   assign trgGpio = phaseCfg.triggerSourceSelect[1:0];

   always_comb
   begin
      armEvent = 1'b0;
      if (phaseCfg.armSourceSelect == ARM_SRC_BIT)
         armEvent = evRise[EV_ARM_BIT];
      else if (phaseCfg.armSourceSelect == ARM_SRC_ANALOG_PLL)
         armEvent = evRise[EV_ANALOG_PLL];
      else if (phaseCfg.armSourceSelect == ARM_SRC_DIGITAL_PLL)
         armEvent = evRise[EV_DIGITAL_PLL];
      else if (phaseCfg.armSourceSelect[3:2] == GPIO_SEL_MSB)
         armEvent = evRise[EV_GPIO0 + armGpio] || evFall[EV_GPIO0 + armGpio];
      // Inverting a rising-edge source makes it fire on the falling edge
      trigEvent = 1'b0;
      if (phaseCfg.triggerSourceSelect == TRG_SRC_BIT)
         trigEvent = phaseCfg.triggerInvert ? evFall[EV_TRIG_BIT] : evRise[EV_TRIG_BIT];
      else if (phaseCfg.triggerSourceSelect == TRG_SRC_ANALOG_PLL)
         trigEvent = phaseCfg.triggerInvert ? evFall[EV_ANALOG_PLL] : evRise[EV_ANALOG_PLL];
      else if (phaseCfg.triggerSourceSelect == TRG_SRC_DIGITAL_PLL)
         trigEvent = phaseCfg.triggerInvert ? evFall[EV_DIGITAL_PLL] : evRise[EV_DIGITAL_PLL];
      else if (phaseCfg.triggerSourceSelect == TRG_SRC_DIGITAL_PLL_IN)
         trigEvent = phaseCfg.triggerInvert ? evFall[EV_DIGITAL_PLL_IN] : evRise[EV_DIGITAL_PLL_IN];
      else if (phaseCfg.triggerSourceSelect[3:2] == GPIO_SEL_MSB)
         trigEvent = phaseCfg.triggerInvert ? evFall[EV_GPIO0 + trgGpio]
            : evRise[EV_GPIO0 + trgGpio];
   end

   // ==========================================================
   // Sequencer and output path
   logic adjApplies;
   logic pClk;
   logic nClk;

   assign adjApplies = phaseCfg.adjustAlignSelect == ADJUST_MODE
      && phaseCfg.perOutputPhaseEnable && (stepClamped != '0) && medUsed;

   always_comb
   begin
      state_next = state_reg;
      // Bypassed medium divider passes the high-speed clock itself
      if (hsTick)
         state_next.hsLevel = !state_reg.hsLevel;
      unique case (state_reg.seq)
         SEQ_IDLE:
         begin
            if (armEvent)
               state_next.seq = SEQ_ARMED;
         end
         SEQ_ARMED:
         begin
            if (trigEvent)
            begin
               state_next.seq = adjApplies ? SEQ_BUSY : SEQ_IDLE;
               state_next.adjPending = adjApplies;
            end
         end
         SEQ_BUSY:
         begin
            if (medRise && state_reg.adjPending)
            begin
               state_next.adjPending = 1'b0;
               state_next.adjActive = 1'b1;
            end
            else if (medRise && state_reg.adjActive)
            begin
               state_next.adjActive = 1'b0;
               state_next.seq = SEQ_IDLE;
            end
            if (!medUsed)
            begin
               state_next.adjPending = 1'b0;
               state_next.adjActive = 1'b0;
               state_next.seq = SEQ_IDLE;
            end
         end
         default:
            state_next.seq = SEQ_IDLE;
      endcase
      if (sequencerReset)
      begin
         state_next.seq = SEQ_IDLE;
         state_next.adjPending = 1'b0;
         state_next.adjActive = 1'b0;
      end
      // A completion in the same cycle as a clear still sets the flag
      if (adjustDoneClear)
         state_next.doneLatch = 1'b0;
      if (state_reg.seq == SEQ_BUSY && state_reg.adjActive && medRise && !sequencerReset)
         state_next.doneLatch = 1'b1;
      state_next.posOut = pClk ^ cfg.outputPolarity;
      state_next.negOut = nClk ^ cfg.outputPolarity;
      state_next.posOeN = !stageRun;
      state_next.negOeN = !stageRun || cfg.outputFormatSelect == FMT_CMOS_P;
      state_next.lowPower = !stageRun;
   end

   always_comb
   begin
      pClk = medUsed ? medOut : state_reg.hsLevel;
      if (lowRun && cfg.lowDividerRoute)
         pClk = lowOut;
      if (!stageRun)
         pClk = 1'b0;
      unique case (cfg.outputFormatSelect)
         FMT_CMOS_SAME: nClk = pClk;
         FMT_CMOS_P: nClk = 1'b0;
         default: nClk = !pClk;
      endcase
      // Dual frequency mode shapes only the negative pin
      if (lowRun && dualMode)
         nClk = lowOut;
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_reg <= '{seq: SEQ_IDLE, posOeN: 1'b1, negOeN: 1'b1, lowPower: 1'b1,
            default: 1'b0};
      else if (ce)
         state_reg <= state_next;
   end

   assign positiveOutputPin = state_reg.posOut;
   assign negativeOutputPin = state_reg.negOut;
   assign positiveOutputOeN = state_reg.posOeN;
   assign negativeOutputOeN = state_reg.negOeN;
   assign driverLowPower = state_reg.lowPower;
   assign phaseStatusReg.statusArmed = state_reg.seq == SEQ_ARMED;
   assign phaseStatusReg.statusBusy = state_reg.seq == SEQ_BUSY;
   assign phaseStatusReg.adjustDoneLatch = state_reg.doneLatch;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_OFF_HIZ: assert property (ce && cfg.outputFormatSelect == FMT_OFF
      |=> positiveOutputOeN && negativeOutputOeN && driverLowPower)
      else $error("disabled output still driven");
   AST_POLARITY: assert property (ce && medUsed && !cfg.lowDividerRoute
      |=> positiveOutputPin == ($past(medOut) ^ $past(cfg.outputPolarity)))
      else $error("positive pin does not follow medium clock with polarity");
   AST_ARM: assert property (ce && state_reg.seq == SEQ_IDLE && armEvent
      && !sequencerReset |=> phaseStatusReg.statusArmed)
      else $error("arm event did not arm");
   AST_SEQ_RESET: assert property (ce && sequencerReset
      |=> !phaseStatusReg.statusArmed && !phaseStatusReg.statusBusy)
      else $error("sequencer reset did not return to idle");
   AST_NO_ADJ: assert property (ce && phaseStatusReg.statusArmed && trigEvent
      && !phaseCfg.perOutputPhaseEnable |=> !phaseStatusReg.statusBusy)
      else $error("disabled output was adjusted");
   AST_DONE_STICKY: assert property (ce && phaseStatusReg.adjustDoneLatch
      && !adjustDoneClear |=> phaseStatusReg.adjustDoneLatch)
      else $error("done flag lost");
   AST_LOW_GATED: assert property (ce && cfg.mediumDividerRatio == '0 |=> !lowOut)
      else $error("low divider running without medium divider");
   AST_STEP_RANGE: assert property (state_reg.adjActive |-> medHigh != '0
      && $signed({1'b0, medHigh}) - $signed({1'b0, medBase}) == stepClamped)
      else $error("adjusted high time does not match the clamped step");
endmodule : hsdv_output_stage
`default_nettype wire

/* File: src/hsdv_pkg.sv */
// Package for the output clock divider and phase adjust stage.
// Assumes one 40 MHz core clock; high-speed divider clocks arrive as half-period strobes.
`default_nettype none
package hsdv_pkg;
   // ==========================================================
   // Clock and widths
   localparam int CORE_CLK_HZ = 40000000;
   localparam int MED_W = 7;
   localparam int LOW_W = 25;
   localparam int MCNT_W = 9;
   localparam int LCNT_W = 27;
   localparam int DUTY_W = 8;
   localparam int STEP_W = 8;
   localparam int EV_W = 9;
   // ==========================================================
   // Event vector bit positions
   localparam int EV_ARM_BIT = 0;
   localparam int EV_TRIG_BIT = 1;
   localparam int EV_ANALOG_PLL = 2;
   localparam int EV_DIGITAL_PLL = 3;
   localparam int EV_DIGITAL_PLL_IN = 4;
   localparam int EV_GPIO0 = 5;
   // ==========================================================
   // Source select codes
   localparam logic [3:0] ARM_SRC_BIT = 4'h1;
   localparam logic [3:0] ARM_SRC_ANALOG_PLL = 4'h2;
   localparam logic [3:0] ARM_SRC_DIGITAL_PLL = 4'h3;
   localparam logic [3:0] ARM_SRC_GPIO0 = 4'h4;
   localparam logic [3:0] TRG_SRC_BIT = 4'h0;
   localparam logic [3:0] TRG_SRC_ANALOG_PLL = 4'h1;
   localparam logic [3:0] TRG_SRC_DIGITAL_PLL = 4'h2;
   localparam logic [3:0] TRG_SRC_DIGITAL_PLL_IN = 4'h3;
   localparam logic [3:0] TRG_SRC_GPIO0 = 4'h4;
   localparam logic [1:0] GPIO_SEL_MSB = 2'h1;
   // ==========================================================
   // Misc constants
   localparam logic [MED_W:0] MED_POS_ODD = 8'h7f;
   localparam logic [MED_W:0] MED_POS_EVEN = 8'h80;
   localparam logic [MED_W-1:0] MED_DUAL_MIN = 7'h05;
   localparam logic [LOW_W-1:0] LOW_DUTY_MIN = 25'h0000002;
   localparam logic ADJUST_MODE = 1'b1;

   typedef enum logic [2:0]
   {
      FMT_OFF = 3'h0,
      FMT_CML = 3'h1,
      FMT_HSTL = 3'h2,
      FMT_CMOS_P = 3'h3,
      FMT_CMOS_SAME = 3'h4,
      FMT_CMOS_INV = 3'h5
   } hsdv_fmt_t;

   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'b00,
      SEQ_ARMED = 2'b01,
      SEQ_BUSY = 2'b10
   } hsdv_seq_t;

   typedef struct packed
   {
      hsdv_fmt_t outputFormatSelect;
      logic outputPolarity;
      logic hsDividerSelect;
      logic dividerEnable;
      logic [MED_W-1:0] mediumDividerRatio;
      logic [LOW_W-1:0] lowDividerRatio;
      logic lowDividerRoute;
      logic negativePinLowDivider;
      logic [DUTY_W-1:0] pulseWidthCount;
   } hsdv_cfg_t;

   typedef struct packed
   {
      logic adjustAlignSelect;
      logic perOutputPhaseEnable;
      logic signed [STEP_W-1:0] phaseStepAmount;
      logic [3:0] armSourceSelect;
      logic [3:0] triggerSourceSelect;
      logic triggerInvert;
   } hsdv_phase_t;

   typedef struct packed
   {
      logic statusArmed;
      logic statusBusy;
      logic adjustDoneLatch;
   } hsdv_status_t;
endpackage : hsdv_pkg
`default_nettype wire

/* File: testbench/hsdv_rx_model.sv */
// Downstream receiver model: measures high and low run lengths of one pin.
// Assumes the pin is sampled on core_clk; a floating pin reads low.
`default_nettype none
module hsdv_rx_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Observed pin
   input wire logic pin,
   input wire logic pinOeN,
   // Run lengths in cycles
   output var int highLen,
   output var int lowLen,
   output var int maxHigh
);
   timeunit 1ns;
   timeprecision 100ps;
   int run;
   logic last;
   always @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         {run, last, highLen, lowLen, maxHigh} <= '0;
      end
      else if ((pinOeN ? 1'b0 : pin) !== last)
      begin
         // Pulled low when released, so no stale level is seen
         if (last)
            highLen <= run;
         else
            lowLen <= run;
         if (last && run > maxHigh)
            maxHigh <= run;
         last <= ~last;
         run <= 1;
      end
      else
         run <= run + 1;
   end
endmodule : hsdv_rx_model
`default_nettype wire

/* File: testbench/tb.sv */
// Testbench for the per-output clock stage: dividers, shaping, phase adjust.
// Assumes a tick every cycle, so one half period equals one cycle.
`default_nettype none
module tb;
   import hsdv_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 0, sys_rst = 1, ce = 1, t1 = 0, t2 = 0;
   hsdv_cfg_t cfg = '0;
   hsdv_phase_t ph = '0;
   logic arm = 0, trg = 0, aLock = 0, dLock = 0, dIn = 0, sRst = 0, dClr = 0;
   logic [3:0] gpio = 4'h0;
   logic pP, pOe, nP, nOe, lowP;
   hsdv_status_t st;
   int pH, pL, pMax, nH, nL, nMax;
   int failures = 0;
   int comparisons = 0;
   always #12.5 core_clk = ~core_clk;
   hsdv_output_stage DUT (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
      .hsHalfTick1(t1), .hsHalfTick2(t2), .cfg(cfg), .phaseCfg(ph),
      .armRequestBit(arm), .triggerRequestBit(trg), .analogPllLock(aLock),
      .digitalPllLock(dLock), .digitalPllInClk(dIn), .gpioIn(gpio),
      .sequencerReset(sRst), .adjustDoneClear(dClr), .positiveOutputPin(pP),
      .positiveOutputOeN(pOe), .negativeOutputPin(nP), .negativeOutputOeN(nOe),
      .driverLowPower(lowP), .phaseStatusReg(st));
   hsdv_rx_model RXP (.core_clk(core_clk), .sys_rst(sys_rst), .pin(pP), .pinOeN(pOe),
      .highLen(pH), .lowLen(pL), .maxHigh(pMax));
   hsdv_rx_model RXN (.core_clk(core_clk), .sys_rst(sys_rst), .pin(nP), .pinOeN(nOe),
      .highLen(nH), .lowLen(nL), .maxHigh(nMax));
   // ==========================================================
   // Shared tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk
   task automatic run(input int n);
      repeat (n) @(negedge core_clk);
   endtask : run
   task automatic do_reset();
      sys_rst = 1;
      run(2);
      sys_rst = 0;
      run(1);
   endtask : do_reset
   task automatic test_done();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   // ==========================================================
   // Scenarios
   task automatic s_off();
      chk("lowPower", 1, lowP);
      chk("status", 0, st);
      cfg.outputFormatSelect = FMT_CML;
      t1 = 1;
      run(20);
      chk("oeN", 1, pOe);
      chk("pHigh", 0, pH);
   endtask : s_off
   task automatic s_div();
      cfg.dividerEnable = 1;
      cfg.mediumDividerRatio = 7'h02;
      run(40);
      chk("pHigh", 3, pH);
      chk("pLow", 3, pL);
      chk("oeN", 0, pOe);
      {cfg.hsDividerSelect, cfg.mediumDividerRatio, t1, t2} = {1'b1, 7'h03, 2'b01};
      run(40);
      chk("sel2High", 4, pH);
   endtask : s_div
   task automatic s_duty();
      do_reset();
      {cfg.mediumDividerRatio, cfg.lowDividerRoute, cfg.pulseWidthCount} = {7'h01, 1'b1, 8'h00};
      {cfg.hsDividerSelect, t1, t2, cfg.lowDividerRatio} = {3'b010, 25'h0000003};
      run(80);
      chk("half", 8, pH);
      cfg.pulseWidthCount = 8'h01;
      run(80);
      chk("pulseHi", 4, pH);
      chk("pulseLo", 12, pL);
      cfg.outputPolarity = 1;
      run(80);
      chk("invHi", 12, pH);
      chk("invLo", 4, pL);
   endtask : s_duty
   task automatic s_dual();
      do_reset();
      {cfg.outputFormatSelect, cfg.outputPolarity} = {FMT_CMOS_SAME, 1'b0};
      {cfg.mediumDividerRatio, cfg.lowDividerRatio} = {7'h05, 25'h0000001};
      {cfg.lowDividerRoute, cfg.negativePinLowDivider} = 2'b01;
      run(120);
      chk("dualP", 6, pH);
      chk("dualN", 12, nH);
      chk("nOeN", 0, nOe);
   endtask : s_dual
   task automatic s_adjust();
      int i;
      do_reset();
      {cfg.outputFormatSelect, cfg.mediumDividerRatio, cfg.pulseWidthCount} = {FMT_CML, 15'h0300};
      {ph.adjustAlignSelect, ph.perOutputPhaseEnable, ph.phaseStepAmount} = {2'b11, 8'sh02};
      {ph.armSourceSelect, ph.triggerSourceSelect} = {ARM_SRC_ANALOG_PLL, TRG_SRC_BIT};
      run(30);
      chk("preMax", 4, pMax);
      aLock = 1;
      run(1);
      chk("armed", 1, st.statusArmed);
      trg = 1;
      run(1);
      chk("busy", 1, st.statusBusy);
      for (i = 0; i < 400 && st.statusBusy !== 1'b0; i++)
         run(1);
      if (i == 400)
      begin
         failures++;
         test_done();
      end
      chk("done", 1, st.adjustDoneLatch);
      chk("stepHi", 6, pMax);
      {dClr, aLock, trg} = 3'b100;
      run(1);
      chk("clear", 0, st.adjustDoneLatch);
      {dClr, aLock} = 2'b01;
      run(1);
      sRst = 1;
      run(1);
      {sRst, trg} = 2'b01;
      run(2);
      chk("cancel", 0, st);
      {ph.phaseStepAmount, aLock, trg} = {8'sh00, 2'b00};
      run(1);
      aLock = 1;
      run(1);
      trg = 1;
      run(2);
      chk("noStep", 0, st);
   endtask : s_adjust
   task automatic s_events();
      {ph.phaseStepAmount, ph.perOutputPhaseEnable, ph.triggerInvert} = {8'sh02, 2'b00};
      {ph.armSourceSelect, ph.triggerSourceSelect, arm} = {ARM_SRC_BIT, TRG_SRC_DIGITAL_PLL_IN, 1'b1};
      run(1);
      chk("armBit", 1, st.statusArmed);
      dIn = 1;
      run(2);
      chk("noEnable", 0, st);
      {ph.armSourceSelect, ph.triggerSourceSelect} = {ARM_SRC_GPIO0, TRG_SRC_GPIO0};
      {ph.perOutputPhaseEnable, ph.triggerInvert, gpio} = {2'b11, 4'h1};
      run(1);
      chk("armGpio", 1, st.statusArmed);
      // Clock enable low must hold the edge history, so the fall lands after it
      {ce, gpio} = {1'b0, 4'h0};
      run(3);
      chk("frozen", 3'b100, st);
      ce = 1;
      run(1);
      chk("trigFall", 1, st.statusBusy);
      run(40);
      chk("gpioDone", 1, st);
   endtask : s_events
   initial
   begin
      do_reset();
      s_off();
      s_div();
      s_duty();
      s_dual();
      s_adjust();
      s_events();
      test_done();
   end
endmodule : tb
`default_nettype wire
